// *** design/count_engine.v ***
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.vh"

module count_engine (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        tick,
  input  wire        gate,
  input  wire        programPulse,
  input  wire [2:0]  modeSel,
  input  wire        bcd,
  input  wire        loadPulse,
  input  wire [15:0] loadValue,
  output reg  [15:0] count,
  output reg         outLevel,
  output reg         transferred
);

  reg        armed_reg;
  reg        running_reg;
  wire [2:0] modeEff;
  wire [15:0] stepOne;
  wire [15:0] stepTwo;

  // Decrement by one, per digit so BCD wraps 0000 to 9999
  function [15:0] decOne;
    input [15:0] v;
    input        isBcd;
    integer      i;
    reg          borrow;
    reg   [3:0]  d;
    begin
      borrow = 1'b1;
      decOne = v;
      for (i = 0; i < 4; i = i + 1) begin
        d = v[i*4 +: 4];
        if (borrow) begin
          if (d == 4'h0) begin
            decOne[i*4 +: 4] = isBcd ? 4'h9 : 4'hF;
          end else begin
            decOne[i*4 +: 4] = d - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
  endfunction

  // Codes 6 and 7 alias the rate and square modes
  assign modeEff = modeSel[1] ? {1'b0, modeSel[1:0]} : modeSel;
  assign stepOne = decOne(count, bcd);
  assign stepTwo = decOne(stepOne, bcd);

  // Counting element, stepped only on the channel clock tick
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count       <= `COUNT_RESET;
      outLevel    <= 1'b0;
      armed_reg   <= 1'b0;
      running_reg <= 1'b0;
      transferred <= 1'b0;
    end else begin
      transferred <= 1'b0;
      if (programPulse) begin
        outLevel    <= (modeEff != `MODE_TERMINAL);
        armed_reg   <= 1'b0;
        running_reg <= 1'b0;
      end else if (loadPulse) begin
        armed_reg <= 1'b1;
        if (modeEff == `MODE_TERMINAL)
          outLevel <= 1'b0;
      end else if (tick) begin
        if (armed_reg) begin
          count       <= loadValue; // R8
          armed_reg   <= 1'b0;
          running_reg <= 1'b1;
          transferred <= 1'b1;
        end else if (running_reg && !gate &&
                     modeEff != `MODE_TERMINAL) begin
          outLevel <= 1'b1; // Gate low parks periodic outputs high
        end else if (running_reg && gate) begin
          case (modeEff)
            `MODE_RATE: begin
              outLevel <= (count != 16'h0002);
              count    <= (count == 16'h0001) ? loadValue : stepOne;
            end
            `MODE_SQUARE: begin
              if (count <= 16'h0002) begin
                outLevel <= ~outLevel;
                count    <= {loadValue[15:1], 1'b0};
              end else begin
                count <= stepTwo;
              end
            end
            default: begin
              if (count == 16'h0001)
                outLevel <= 1'b1;
              count <= stepOne; // R4
            end
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** design/interval_timer_consts.vh ***
`ifndef INTERVAL_TIMER_CONSTS_VH
`define INTERVAL_TIMER_CONSTS_VH

// Port codes on the two port select bits
`define PORT_CHAN0        2'h0
`define PORT_CHAN1        2'h1
`define PORT_CHAN2        2'h2
`define PORT_MODE_WORD    2'h3

// Mode programming word fields
`define CW_SEL_HI         7
`define CW_SEL_LO         6
`define CW_RW_HI          5
`define CW_RW_LO          4
`define CW_MODE_HI        3
`define CW_MODE_LO        1
`define CW_BCD            0
`define CW_CHAN_BIT0      1
`define SEL_READBACK      2'h3
`define RB_NO_COUNT_BIT   5
`define RB_NO_STATUS_BIT  4

// Read/write format codes
`define RW_LATCH          2'h0
`define RW_LSB            2'h1
`define RW_MSB            2'h2
`define RW_BOTH           2'h3

// Counting modes handled by the count engine
`define MODE_TERMINAL     3'h0
`define MODE_RATE         3'h2
`define MODE_SQUARE       3'h3

// Reset values
`define CHAN_WORD_RESET   6'h00
`define PIN_SYNC_RESET    13'h0007
`define COUNT_RESET       16'h0000

`endif

// *** design/interval_timer_counter_datapath.v ***
// Summary of operation
// R1 - Write to port 11 stores mode word
// R2 - Mode port write-only; status via snapshot command
// R3 - Three identical independent channels, own modes
// R4 - Each channel 16-bit synchronous down counter
// R5 - Snapshot latch tracks, freezes until read
// R6 - Counter reads return snapshot latch only
// R7 - One snapshot byte per read
// R8 - Writes fill holding bytes, moved together
// R9 - Programming clears both holding bytes
// R10 - Status holds mode word, output, pending flag
// R11 - State undefined until channel programmed
// R12 - Host programs channel before relying on it
// R13 - Host writes mode word, then count
// R14 - Channel chosen by mode word field
// R15 - Four ports: three counters, one mode
// R16 - Port bits 00/01/10 channels, 11 mode
// R17 - Strobes ignored without device select
// R18 - Strobes synchronised, edge detected, act once
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.vh"

module interval_timer_counter_datapath #(
  parameter CHANNELS = 3
) (
  input  wire                clk,
  input  wire                reset_n,
  input  wire                chipSelect_n,
  input  wire                readStrobe_n,
  input  wire                writeStrobe_n,
  input  wire [1:0]          port_select_bits,
  input  wire [7:0]          dataIn,
  output reg  [7:0]          dataOut,
  output reg                 dataOe,
  input  wire [CHANNELS-1:0] chanClk,
  input  wire [CHANNELS-1:0] chanGate,
  output wire [CHANNELS-1:0] chanOut
);

  // Synchronised bus pins
  wire [12:0] busSync;
  wire        csN;
  wire        rdN;
  wire        wrN;
  wire [1:0]  portNow;
  wire [7:0]  dataNow;

  reg         csPrevN_reg;
  reg         rdPrevN_reg;
  reg         wrPrevN_reg;
  reg  [1:0]  portPrev_reg;
  reg  [7:0]  dataPrev_reg;

  // Synchronised channel pins
  wire [2*CHANNELS-1:0] chanSync;
  wire [CHANNELS-1:0]   chanClkSync;
  wire [CHANNELS-1:0]   chanGateSync;
  reg  [CHANNELS-1:0]   chanClkPrev_reg;
  wire [CHANNELS-1:0]   chanTick;

  // Host events, one cycle each
  wire        wrEvent;
  wire        rdStart;
  wire        rdEnd;
  wire        modeWrite;
  wire        readBack;
  wire [1:0]  wordSel;

  wire [8*CHANNELS-1:0] chanByteFlat;
  reg  [7:0]            readByte;

  // All bus pins cross together so address and data line up
  sync_stage #(
    .WIDTH       (13),
    .RESET_VALUE (`PIN_SYNC_RESET)
  ) busSyncer (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn ({dataIn, port_select_bits, writeStrobe_n,
               readStrobe_n, chipSelect_n}),
    .syncOut (busSync)
  );

  assign csN     = busSync[0];
  assign rdN     = busSync[1];
  assign wrN     = busSync[2];
  assign portNow = busSync[4:3];
  assign dataNow = busSync[12:5];

  sync_stage #(
    .WIDTH       (2*CHANNELS),
    .RESET_VALUE ({(2*CHANNELS){1'b0}})
  ) chanSyncer (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn ({chanGate, chanClk}),
    .syncOut (chanSync)
  );

  assign chanClkSync  = chanSync[CHANNELS-1:0];
  assign chanGateSync = chanSync[2*CHANNELS-1:CHANNELS];

  // Previous samples for edge detection
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csPrevN_reg     <= 1'b1;
      rdPrevN_reg     <= 1'b1;
      wrPrevN_reg     <= 1'b1;
      portPrev_reg    <= 2'h0;
      dataPrev_reg    <= 8'h00;
      chanClkPrev_reg <= {CHANNELS{1'b0}};
    end else begin
      csPrevN_reg     <= csN;
      rdPrevN_reg     <= rdN;
      wrPrevN_reg     <= wrN;
      portPrev_reg    <= portNow;
      dataPrev_reg    <= dataNow;
      chanClkPrev_reg <= chanClkSync;
    end
  end

  // Channel clocks become one-cycle enables on their rising edge
  assign chanTick = chanClkSync & ~chanClkPrev_reg;

  // Write acts at the strobe's trailing edge, when data is settled
  assign wrEvent = wrN & ~wrPrevN_reg & ~csPrevN_reg; // R18 R17
  assign rdStart = ~rdN & rdPrevN_reg & ~csN;         // R18 R17
  assign rdEnd   = rdN & ~rdPrevN_reg & ~csPrevN_reg; // R18

  assign modeWrite = wrEvent &&
                     (portPrev_reg == `PORT_MODE_WORD); // R1 R16
  assign wordSel   = dataPrev_reg[`CW_SEL_HI:`CW_SEL_LO]; // R14
  assign readBack  = (wordSel == `SEL_READBACK);

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : chan
      localparam integer CH_INDEX = g;
      localparam [1:0]   CH       = CH_INDEX[1:0];

      reg  [5:0]  modeWord_reg;
      reg  [7:0]  count_holding_lo;
      reg  [7:0]  count_holding_hi;
      reg  [7:0]  snapshot_latch_lo;
      reg  [7:0]  snapshot_latch_hi;
      reg  [7:0]  status_reg;
      reg         statusPending_reg;
      reg         frozen_reg;
      reg         writeHiNext_reg;
      reg         readHiNext_reg;
      reg         nullCount_reg;
      reg         loadPulse_reg;
      reg         programPulse_reg;

      wire [1:0]  rwFmt;
      wire        addressed;
      wire        progHit;
      wire        latchHit;
      wire        statHit;
      wire        cntWrite;
      wire        cntRead;
      wire        lastByte;
      wire        hiSel;
      wire [15:0] count;
      wire        transferred;
      wire        hiLoad;

      assign rwFmt     = modeWord_reg[`CW_RW_HI:`CW_RW_LO];
      assign addressed = readBack ?
                         dataPrev_reg[`CW_CHAN_BIT0 + g] :
                         (wordSel == CH); // R14
      assign progHit   = modeWrite && !readBack && addressed &&
                         dataPrev_reg[`CW_RW_HI:`CW_RW_LO] != `RW_LATCH;
      assign latchHit  = modeWrite && addressed &&
                         (readBack ?
                          !dataPrev_reg[`RB_NO_COUNT_BIT] :
                          dataPrev_reg[`CW_RW_HI:`CW_RW_LO] ==
                          `RW_LATCH);
      assign statHit   = modeWrite && readBack && addressed &&
                         !dataPrev_reg[`RB_NO_STATUS_BIT];
      assign cntWrite  = wrEvent && (portPrev_reg == CH); // R15
      assign cntRead   = rdEnd && (portPrev_reg == CH);
      assign hiSel     = (rwFmt == `RW_MSB) ||
                         (rwFmt == `RW_BOTH && readHiNext_reg);
      assign lastByte  = (rwFmt != `RW_BOTH) || readHiNext_reg;
      assign hiLoad    = (rwFmt == `RW_MSB) ||
                         (rwFmt == `RW_BOTH && writeHiNext_reg);

      // Pending status first, then one snapshot byte
      assign chanByteFlat[8*g +: 8] =
        statusPending_reg ? status_reg :
        (hiSel ? snapshot_latch_hi : snapshot_latch_lo); // R6 R7 R10

      // Mode word, holding bytes and byte pointers of this channel
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          modeWord_reg     <= `CHAN_WORD_RESET; // R11
          count_holding_lo <= 8'h00;
          count_holding_hi <= 8'h00;
          writeHiNext_reg  <= 1'b0;
          readHiNext_reg   <= 1'b0;
          loadPulse_reg    <= 1'b0;
          programPulse_reg <= 1'b0;
        end else begin
          loadPulse_reg    <= 1'b0;
          programPulse_reg <= progHit;
          if (progHit) begin
            modeWord_reg     <= dataPrev_reg[5:0]; // R1 R3
            count_holding_lo <= 8'h00; // R9
            count_holding_hi <= 8'h00; // R9
            writeHiNext_reg  <= 1'b0;
            readHiNext_reg   <= 1'b0;
          end else begin
            if (cntWrite && rwFmt != `RW_LATCH) begin
              if (hiLoad)
                count_holding_hi <= dataPrev_reg; // R8
              else
                count_holding_lo <= dataPrev_reg; // R8
              if (rwFmt == `RW_BOTH)
                writeHiNext_reg <= ~writeHiNext_reg;
              // Both-bytes format only loads after the high byte
              loadPulse_reg <= (rwFmt != `RW_BOTH) ||
                               writeHiNext_reg; // R8
            end
            if (cntRead && !statusPending_reg &&
                rwFmt == `RW_BOTH)
              readHiNext_reg <= ~readHiNext_reg; // R7
          end
        end
      end

      // Snapshot latch follows the count unless frozen
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          snapshot_latch_lo <= 8'h00;
          snapshot_latch_hi <= 8'h00;
          frozen_reg        <= 1'b0;
        end else begin
          if (!frozen_reg && !latchHit) begin
            snapshot_latch_lo <= count[7:0];  // R5
            snapshot_latch_hi <= count[15:8]; // R5
          end
          // A second freeze before the read is ignored
          if (progHit)
            frozen_reg <= 1'b0;
          else if (latchHit)
            frozen_reg <= 1'b1; // R5
          else if (cntRead && !statusPending_reg && lastByte)
            frozen_reg <= 1'b0; // R5
        end
      end

      // Status snapshot and reload-pending flag
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          status_reg        <= 8'h00;
          statusPending_reg <= 1'b0;
          nullCount_reg     <= 1'b0;
        end else begin
          if (statHit && !statusPending_reg) begin
            status_reg <= {chanOut[g], nullCount_reg,
                           modeWord_reg}; // R10 R2
            statusPending_reg <= 1'b1;
          end else if (cntRead) begin
            statusPending_reg <= 1'b0;
          end
          // New count pending wins over a transfer in the same cycle
          if (progHit || loadPulse_reg)
            nullCount_reg <= 1'b1;
          else if (transferred)
            nullCount_reg <= 1'b0;
        end
      end

      count_engine engine (
        .clk          (clk),
        .reset_n      (reset_n),
        .tick         (chanTick[g]),
        .gate         (chanGateSync[g]),
        .programPulse (programPulse_reg),
        .modeSel      (modeWord_reg[`CW_MODE_HI:`CW_MODE_LO]),
        .bcd          (modeWord_reg[`CW_BCD]),
        .loadPulse    (loadPulse_reg),
        .loadValue    ({count_holding_hi, count_holding_lo}),
        .count        (count),
        .outLevel     (chanOut[g]),
        .transferred  (transferred)
      ); // R3 R4
    end
  endgenerate

  // Select the addressed channel's byte
  always @* begin
    readByte = 8'h00;
    case (portNow)
      `PORT_CHAN0: readByte = chanByteFlat[7:0];
      `PORT_CHAN1: readByte = chanByteFlat[15:8];
      `PORT_CHAN2: readByte = chanByteFlat[8*CHANNELS-1:16];
      default:     readByte = 8'h00;
    endcase
  end

  // Data bus drive; the mode port never answers a read
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dataOut <= 8'h00;
      dataOe  <= 1'b0;
    end else begin
      if (rdStart && portNow != `PORT_MODE_WORD) begin
        dataOut <= readByte; // R6
        dataOe  <= 1'b1;
      end else if (rdN || csN) begin
        dataOe  <= 1'b0; // R2 R17
      end
    end
  end

endmodule

`default_nettype wire

// *** design/sync_stage.v ***
`timescale 1ns/1ps
`default_nettype none

module sync_stage #(
  parameter               WIDTH       = 1,
  parameter [WIDTH-1:0]   RESET_VALUE = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] firstStage_reg;

  // Two flops; only the second stage is visible to logic
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      firstStage_reg <= RESET_VALUE;
      syncOut        <= RESET_VALUE;
    end else begin
      firstStage_reg <= asyncIn;
      syncOut        <= firstStage_reg;
    end
  end

endmodule

`default_nettype wire

// *** test/host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
  input  wire logic       clk,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  output var  logic       chipSelect_n,
  output var  logic       readStrobe_n,
  output var  logic       writeStrobe_n,
  output var  logic [1:0] portSel,
  output var  logic [7:0] dataIn
);
  // Idle bus at time zero
  initial begin
    chipSelect_n = 1'b1;
    readStrobe_n = 1'b1;
    writeStrobe_n = 1'b1;
    portSel = 2'h0;
    dataIn = 8'h00;
  end

  // Strobe held 4 clk, qualifiers 4 clk past it: covers the sync delay
  task automatic writePort(input logic sel_n, input logic [1:0] port,
                           input logic [7:0] data);
    @(negedge clk);
    chipSelect_n = sel_n;
    portSel = port;
    dataIn = data;
    writeStrobe_n = 1'b0;
    repeat (4) @(negedge clk);
    writeStrobe_n = 1'b1;
    repeat (4) @(negedge clk);
    chipSelect_n = 1'b1;
    portSel = ~port;
    dataIn = ~data; // Released lines never show the old byte
  endtask

  // Answer taken well after its worst-case 3 clk latency
  task automatic readPort(input logic sel_n, input logic [1:0] port,
                          output logic [7:0] data, output logic oe);
    @(negedge clk);
    chipSelect_n = sel_n;
    portSel = port;
    readStrobe_n = 1'b0;
    repeat (6) @(negedge clk);
    data = dataOut;
    oe = dataOe;
    readStrobe_n = 1'b1;
    repeat (5) @(negedge clk);
    chipSelect_n = 1'b1;
    portSel = ~port;
  endtask
endmodule

`default_nettype wire

// *** test/interval_timer_counter_datapath_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

module interval_timer_counter_datapath_properties #(
  parameter CHANNELS = 3
) (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                chipSelect_n,
  input wire logic                readStrobe_n,
  input wire logic                writeStrobe_n,
  input wire logic [1:0]          port_select_bits,
  input wire logic [7:0]          dataIn,
  input wire logic [7:0]          dataOut,
  input wire logic                dataOe,
  input wire logic [CHANNELS-1:0] chanClk,
  input wire logic [CHANNELS-1:0] chanGate,
  input wire logic [CHANNELS-1:0] chanOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Rate mode word for channel 2 held low, then the strobe released
  sequence rateWordCh2(logic sel);
    (chipSelect_n == sel) && !writeStrobe_n && port_select_bits == 2'h3 &&
    dataIn[7:6] == 2'h2 && dataIn[3:1] == 3'h2 && !chanClk[2]
    ##1 writeStrobe_n;
  endsequence

  // Bus drive only answers a selected read, never of the mode port
  AST_OE_NEEDS_READ: assert property ($rose(dataOe) |->
    !$past(readStrobe_n, 2) && !$past(chipSelect_n, 2))
    else $error("data drive without a selected read");
  AST_NO_MODE_READ: assert property ($rose(dataOe) |->
    $past(port_select_bits, 3) != 2'h3)
    else $error("mode port answered a read");
  AST_OE_RELEASE: assert property ($rose(readStrobe_n) |->
    ##[1:5] !dataOe)
    else $error("data drive kept after read ended");
  AST_BYTE_STEADY: assert property (dataOe && $past(dataOe) |->
    $stable(dataOut))
    else $error("read byte changed during read");
  AST_QUIET_UNSELECTED: assert property (chipSelect_n [*8] |->
    !dataOe)
    else $error("data driven while unselected");
  AST_WRITE_NO_DRIVE: assert property (!writeStrobe_n [*6] |->
    !dataOe)
    else $error("data driven during a write");
  // Output level follows programming, only when selected
  AST_PROGRAM_SETS_OUT: assert property (rateWordCh2(1'b0) |->
    ##[2:8] chanOut[2])
    else $error("rate mode word did not raise output");
  AST_UNSELECTED_WRITE: assert property (rateWordCh2(1'b1) |->
    $stable(chanOut[2]) [*8])
    else $error("unselected write changed output");
endmodule

bind interval_timer_counter_datapath
  interval_timer_counter_datapath_properties #(.CHANNELS(CHANNELS)) checkU (
  .clk(clk), .reset_n(reset_n), .chipSelect_n(chipSelect_n),
  .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
  .port_select_bits(port_select_bits), .dataIn(dataIn), .dataOut(dataOut),
  .dataOe(dataOe), .chanClk(chanClk), .chanGate(chanGate),
  .chanOut(chanOut));

`default_nettype wire

// *** test/interval_timer_counter_datapath_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module interval_timer_counter_datapath_tb;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       chipSelect_n, readStrobe_n, writeStrobe_n, dataOe, rdOe;
  logic [1:0] portSel;
  logic [7:0] dataIn, dataOut, rdData;
  logic [2:0] chanClk = 3'h0;
  logic [2:0] chanGate = 3'h7;
  logic [2:0] chanOut;
  int         mismatches = 0;
  int         tests_run = 0;
  int         cycles = 0;

  // 25 MHz system clock
  always #20 clk = ~clk;

  interval_timer_counter_datapath dut_u (
    .clk(clk), .reset_n(reset_n), .chipSelect_n(chipSelect_n),
    .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
    .port_select_bits(portSel), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .chanClk(chanClk), .chanGate(chanGate),
    .chanOut(chanOut));

  host_bus_model hostU (
    .clk(clk), .dataOut(dataOut), .dataOe(dataOe),
    .chipSelect_n(chipSelect_n), .readStrobe_n(readStrobe_n),
    .writeStrobe_n(writeStrobe_n), .portSel(portSel), .dataIn(dataIn));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run needs about 540 clk; a hang is cut well beyond that
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] port, input logic [7:0] data);
    hostU.writePort(1'b0, port, data);
  endtask

  task automatic rdCheck(input logic [1:0] port, input logic [7:0] exp,
                         input string what);
    hostU.readPort(1'b0, port, rdData, rdOe);
    check(what, rdData, exp);
  endtask

  // Slow channel clock pulses, 4 clk high and 4 low, so none are lost
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(negedge clk);
      chanClk[ch] = 1'b1;
      repeat (4) @(negedge clk);
      chanClk[ch] = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask

  // Main sequence: every channel is programmed before use
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    // Channel 0: mode 0, both bytes, count 1234 then down counting
    wr(2'h3, 8'h30);
    wr(2'h0, 8'h34);
    wr(2'h0, 8'h12);
    pulse(0, 1);
    rdCheck(2'h0, 8'h34, "ch0 lo");
    rdCheck(2'h0, 8'h12, "ch0 hi");
    pulse(0, 2);
    rdCheck(2'h0, 8'h32, "ch0 lo");
    rdCheck(2'h0, 8'h12, "ch0 hi");
    // Frozen pair survives three ticks, then tracking resumes
    wr(2'h3, 8'h00);
    pulse(0, 3);
    rdCheck(2'h0, 8'h32, "frozen lo");
    rdCheck(2'h0, 8'h12, "frozen hi");
    rdCheck(2'h0, 8'h2F, "live lo");
    rdCheck(2'h0, 8'h12, "live hi");
    // Status snapshot comes first and leaves the byte pointer alone
    wr(2'h3, 8'hE2);
    rdCheck(2'h0, 8'h30, "ch0 status");
    rdCheck(2'h0, 8'h2F, "lo after status");
    rdCheck(2'h0, 8'h12, "hi after status");
    hostU.readPort(1'b0, 2'h3, rdData, rdOe);
    check("mode port drive", {7'h00, rdOe}, 8'h00);
    // Channel 1: msb-only reload must bring a zero low byte
    wr(2'h3, 8'h70);
    wr(2'h1, 8'hFF);
    wr(2'h1, 8'hFF);
    pulse(1, 1);
    wr(2'h3, 8'h60);
    wr(2'h1, 8'hAB);
    pulse(1, 2);
    rdCheck(2'h1, 8'hAA, "ch1 hi");
    rdCheck(2'h0, 8'h2F, "ch0 untouched");
    rdCheck(2'h0, 8'h12, "ch0 untouched");
    // Channel 2: unselected strobes do nothing, selected ones program
    hostU.writePort(1'b1, 2'h3, 8'h94);
    repeat (4) @(negedge clk);
    check("outs unselected", {5'h00, chanOut}, 8'h00);
    wr(2'h3, 8'h94);
    repeat (4) @(negedge clk);
    check("outs ch2 rate", {5'h00, chanOut}, 8'h04);
    hostU.readPort(1'b1, 2'h0, rdData, rdOe);
    check("unselected read", {7'h00, rdOe}, 8'h00);
    wr(2'h2, 8'h56);
    pulse(2, 1);
    rdCheck(2'h2, 8'h56, "ch2 lo");
    // Read-back freezes ch1 and ch2 together; ch0 counts in BCD
    wr(2'h3, 8'hDC);
    pulse(2, 1);
    rdCheck(2'h2, 8'h56, "rb frozen ch2");
    rdCheck(2'h2, 8'h55, "ch2 live");
    rdCheck(2'h1, 8'hAA, "rb frozen ch1");
    wr(2'h3, 8'h11);
    wr(2'h3, 8'hE2);
    rdCheck(2'h0, 8'h51, "ch0 status pending");
    wr(2'h0, 8'h10);
    pulse(0, 2);
    rdCheck(2'h0, 8'h09, "ch0 bcd");
    wrap_up();
  end
endmodule

`default_nettype wire
